// ===== rtl/pic_defs.vh
// Purpose: constants for the prioritising interrupt controller
// Assumes: included by the design top and its bench
// Notes:   printed offsets are register indices, byte address = 4 * index
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH

// register indices
`define PIC_IDX_PEND0      12'hfc0
`define PIC_IDX_ENH0       12'hfc1
`define PIC_IDX_ENL0       12'hfc2
`define PIC_IDX_PEND1      12'hfc3
`define PIC_IDX_ENH1       12'hfc4
`define PIC_IDX_ENL1       12'hfc5
`define PIC_IDX_PEND2      12'hfc6
`define PIC_IDX_ENH2       12'hfc7
`define PIC_IDX_ENL2       12'hfc8
`define PIC_IDX_CTRL       12'hfcf

// control register field
`define PIC_CTRL_ME_BIT    7

// implemented bits per group, reserved bits read as zero
`define PIC_MASK_G0        8'h61
`define PIC_MASK_G1        8'hff
`define PIC_MASK_G2        8'h0f
`define PIC_RST_BYTE       8'h00

// vector of group g, bit b is base_g - 2*b
`define PIC_VBASE_G0       16'h0016
`define PIC_VBASE_G1       16'h0026
`define PIC_VBASE_G2       16'h0036
`define PIC_VEC_WDT        16'h0004
`define PIC_VEC_POSC       16'h003a
`define PIC_VEC_WOSC       16'h003c
`define PIC_VEC_ILL        16'h0006

// register select codes
`define PIC_SEL_NONE       4'h0
`define PIC_SEL_CTRL       4'h1
`define PIC_SEL_PEND       4'h2
`define PIC_SEL_ENH        4'h5
`define PIC_SEL_ENL        4'h8

// bus responses
`define PIC_RESP_OKAY      2'b00
`define PIC_RESP_SLVERR    2'b10

`endif

// ===== rtl/pic_top.v
// Purpose: prioritising interrupt controller with an AXI4-Lite register port
// Assumes: all inputs synchronous to SYS_CLK_I; request pulses one cycle wide
// Notes:   system events are levels held by their source until serviced
//
// Summary of operation
// - master enable cleared: only illegal and oscillator traps are forwarded with a vector
// - master enable set by unmask instruction, service return or written 1
// - master enable cleared by reset, mask, written 0, ack and traps
// - three priority levels per source, three highest, one lowest
// - a higher level always beats any lower level in arbitration
// - equal levels resolve by vector order, port C pin 0 last
// - watchdog interrupt and traps outrank every programmable source
// - sources pulse one clock; the pulse is latched into its pending bit
// - acknowledge clears only the pending bit of the forwarded source
// - writing 0 to a pending bit clears it
// - writing 1 to a pending bit raises a request like hardware
// - a source request sets its pending bit to 1
// - master enable set: pending enabled requests go to the CPU
// - pending bits accumulate while disabled and can be polled
// - group 0: timer 1 bit 6, timer 0 bit 5, converter bit 0
// - group 1: port A pins 7..0, bit 6 shared with comparator
// - group 2: port C pins 3..0, upper bits reserved
// - watchdog and oscillator traps hold no state in these registers
// - enable high/low pair selects disabled, level 1, 2 or 3
// - vector MSB at even address, LSB at the following odd address
`timescale 1ns/100ps
`include "pic_defs.vh"

module pic_top (
    // clock, reset, enable
    input  wire        SYS_CLK_I,
    input  wire        RST_B_I,
    input  wire        CLK_EN_I,
    // peripheral request pulses
    input  wire        TIMER1_REQ_I,
    input  wire        TIMER0_REQ_I,
    input  wire        CONVERTER_REQ_I,
    input  wire [7:0]  PORTA_REQ_I,
    input  wire [3:0]  PORTC_REQ_I,
    // cpu events
    input  wire        GLOBAL_UNMASK_INSTR_I,
    input  wire        GLOBAL_MASK_INSTR_I,
    input  wire        RETURN_FROM_SERVICE_INSTR_I,
    input  wire        TRAP_INSTR_I,
    input  wire        ILLEGAL_TRAP_I,
    input  wire        PRI_OSC_FAIL_I,
    input  wire        WDT_OSC_FAIL_I,
    input  wire        WDT_INT_I,
    // cpu request and acknowledge
    input  wire        INT_ACK_I,
    output reg         INT_REQ_O,
    output reg         INT_SYS_O,
    output reg  [15:0] INT_VEC_MSB_ADDR_O,
    output reg  [15:0] INT_VEC_LSB_ADDR_O,
    output wire        MASTER_INT_ENABLE_O,
    // axi4-lite write address
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [13:0] S_AXI_AWADDR,
    input  wire [2:0]  S_AXI_AWPROT,
    // axi4-lite write data
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    // axi4-lite write response
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    output reg  [1:0]  S_AXI_BRESP,
    // axi4-lite read address
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    input  wire [13:0] S_AXI_ARADDR,
    input  wire [2:0]  S_AXI_ARPROT,
    // axi4-lite read data
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP
);

    // register state, flat index g*8+b
    reg  [23:0] pend_q;
    reg  [23:0] enh_q;
    reg  [23:0] enl_q;
    reg         me_q;
    reg  [4:0]  src_q;
    reg         src_vld_q;

    // write channel holding
    reg         aw_full_q;
    reg  [13:0] aw_addr_q;
    reg         w_full_q;
    reg  [7:0]  w_data_q;
    reg         w_strb_q;

    wire [23:0] impl_mask = {`PIC_MASK_G2, `PIC_MASK_G1, `PIC_MASK_G0};

    // decode byte address to a select code plus group in low bits
    function [3:0] reg_sel;
        input [13:0] addr;
        begin
            reg_sel = `PIC_SEL_NONE;
            if (addr[1:0] == 2'b00) begin
                case (addr[13:2])
                    `PIC_IDX_CTRL:  reg_sel = `PIC_SEL_CTRL;
                    `PIC_IDX_PEND0: reg_sel = `PIC_SEL_PEND;
                    `PIC_IDX_PEND1: reg_sel = `PIC_SEL_PEND + 4'h1;
                    `PIC_IDX_PEND2: reg_sel = `PIC_SEL_PEND + 4'h2;
                    `PIC_IDX_ENH0:  reg_sel = `PIC_SEL_ENH;
                    `PIC_IDX_ENH1:  reg_sel = `PIC_SEL_ENH + 4'h1;
                    `PIC_IDX_ENH2:  reg_sel = `PIC_SEL_ENH + 4'h2;
                    `PIC_IDX_ENL0:  reg_sel = `PIC_SEL_ENL;
                    `PIC_IDX_ENL1:  reg_sel = `PIC_SEL_ENL + 4'h1;
                    `PIC_IDX_ENL2:  reg_sel = `PIC_SEL_ENL + 4'h2;
                    default:        reg_sel = `PIC_SEL_NONE;
                endcase
            end
        end
    endfunction

    // first requester in vector order: group ascending, bit descending
    function [5:0] pick_first;
        input [23:0] req;
        integer g;
        integer b;
        begin
            pick_first = 6'h00;
            for (g = 2; g >= 0; g = g - 1) begin
                for (b = 0; b < 8; b = b + 1) begin
                    if (req[g*8+b]) begin
                        pick_first = {1'b1, g[1:0], b[2:0]};
                    end
                end
            end
        end
    endfunction

    wire [23:0] lvl3 = pend_q & impl_mask & enh_q & enl_q;
    wire [23:0] lvl2 = pend_q & impl_mask & enh_q & ~enl_q;
    wire [23:0] lvl1 = pend_q & impl_mask & ~enh_q & enl_q;

    wire [5:0] win3 = pick_first(lvl3);
    wire [5:0] win2 = pick_first(lvl2);
    wire [5:0] win1 = pick_first(lvl1);

    // level 3 over 2 over 1; order inside pick_first
    // disabled pairs appear in no level mask
    reg  [5:0]  win;
    always @* begin
        if (win3[5])
            win = win3;
        else if (win2[5])
            win = win2;
        else
            win = win1;
    end

    // vector msb address even, lsb address odd
    reg  [15:0] vbase;
    always @* begin
        case (win[4:3])
            2'd0:    vbase = `PIC_VBASE_G0;
            2'd1:    vbase = `PIC_VBASE_G1;
            default: vbase = `PIC_VBASE_G2;
        endcase
    end
    wire [15:0] src_vec = vbase - {12'h000, win[2:0], 1'b0};

    reg         sys_hit;
    reg  [15:0] sys_vec;
    always @* begin
        sys_hit = 1'b1;
        sys_vec = `PIC_VEC_ILL;
        if (WDT_INT_I && me_q)
            sys_vec = `PIC_VEC_WDT;
        else if (PRI_OSC_FAIL_I)
            sys_vec = `PIC_VEC_POSC;
        else if (WDT_OSC_FAIL_I)
            sys_vec = `PIC_VEC_WOSC;
        else if (!ILLEGAL_TRAP_I)
            sys_hit = 1'b0;
    end

    // vectored forwarding only while master enable set
    wire        fwd_src = me_q && win[5] && !sys_hit;

    // bus write strobes
    wire        wr_go   = CLK_EN_I && aw_full_q && w_full_q && !S_AXI_BVALID;
    wire [3:0]  wr_sel  = reg_sel(aw_addr_q);
    wire        wr_en   = wr_go && w_strb_q;
    wire [3:0]  rd_sel  = reg_sel(S_AXI_ARADDR);

    assign S_AXI_AWREADY = CLK_EN_I && !aw_full_q && !S_AXI_BVALID;
    assign S_AXI_WREADY  = CLK_EN_I && !w_full_q && !S_AXI_BVALID;
    assign S_AXI_ARREADY = CLK_EN_I && !S_AXI_RVALID;
    assign MASTER_INT_ENABLE_O = me_q;

    wire [23:0] hw_set = {4'h0, PORTC_REQ_I, PORTA_REQ_I,
                          1'b0, TIMER1_REQ_I, TIMER0_REQ_I, 4'h0,
                          CONVERTER_REQ_I};

    wire        ack_src = INT_ACK_I && INT_REQ_O && src_vld_q;

    genvar gi;
    generate
        for (gi = 0; gi < 24; gi = gi + 1) begin : g_pend
            wire impl   = impl_mask[gi];
            wire wr_p   = wr_en && (wr_sel == `PIC_SEL_PEND + (gi / 8));
            wire wr_h   = wr_en && (wr_sel == `PIC_SEL_ENH + (gi / 8));
            wire wr_l   = wr_en && (wr_sel == `PIC_SEL_ENL + (gi / 8));
            wire ack_me = ack_src && (src_q == gi);
            always @(posedge SYS_CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    pend_q[gi] <= 1'b0;
                    enh_q[gi]  <= 1'b0;
                    enl_q[gi]  <= 1'b0;
                end else if (CLK_EN_I) begin
                    // hardware set wins over any clear
                    if (impl && hw_set[gi])
                        pend_q[gi] <= 1'b1;
                    // write 0 clears, write 1 sets
                    else if (wr_p)
                        pend_q[gi] <= impl & w_data_q[gi % 8];
                    else if (ack_me)
                        pend_q[gi] <= 1'b0;
                    if (wr_h)
                        enh_q[gi] <= impl & w_data_q[gi % 8];
                    if (wr_l)
                        enl_q[gi] <= impl & w_data_q[gi % 8];
                end
            end
        end
    endgenerate

    wire me_clr = GLOBAL_MASK_INSTR_I || TRAP_INSTR_I || ILLEGAL_TRAP_I
                  || PRI_OSC_FAIL_I || WDT_OSC_FAIL_I
                  || (INT_ACK_I && INT_REQ_O);
    wire me_set = GLOBAL_UNMASK_INSTR_I || RETURN_FROM_SERVICE_INSTR_I;
    wire me_wr  = wr_en && (wr_sel == `PIC_SEL_CTRL);

    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            me_q <= 1'b0;
        end else if (CLK_EN_I) begin
            if (me_clr)
                me_q <= 1'b0;
            else if (me_set)
                me_q <= 1'b1;
            // software write of 1 or 0
            else if (me_wr)
                me_q <= w_data_q[`PIC_CTRL_ME_BIT];
        end
    end

    // request outputs; dropped at the ack edge so no stale cycle shows
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            INT_REQ_O          <= 1'b0;
            INT_SYS_O          <= 1'b0;
            INT_VEC_MSB_ADDR_O <= 16'h0000;
            INT_VEC_LSB_ADDR_O <= 16'h0000;
            src_q              <= 5'h00;
            src_vld_q          <= 1'b0;
        end else if (CLK_EN_I) begin
            if (INT_ACK_I && INT_REQ_O) begin
                INT_REQ_O <= 1'b0;
                INT_SYS_O <= 1'b0;
                src_vld_q <= 1'b0;
            end else if (sys_hit) begin
                // system vectors come straight from inputs
                INT_REQ_O          <= 1'b1;
                INT_SYS_O          <= 1'b1;
                src_vld_q          <= 1'b0;
                INT_VEC_MSB_ADDR_O <= sys_vec;
                INT_VEC_LSB_ADDR_O <= sys_vec | 16'h0001;
            end else begin
                // forward winner; else keep polling only
                INT_REQ_O          <= fwd_src;
                INT_SYS_O          <= 1'b0;
                src_vld_q          <= fwd_src;
                src_q              <= win[4:0];
                INT_VEC_MSB_ADDR_O <= src_vec;
                INT_VEC_LSB_ADDR_O <= src_vec | 16'h0001;
            end
        end
    end

    // axi write path: address and data taken in either order
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_full_q    <= 1'b0;
            aw_addr_q    <= 14'h0000;
            w_full_q     <= 1'b0;
            w_data_q     <= 8'h00;
            w_strb_q     <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `PIC_RESP_OKAY;
        end else if (CLK_EN_I) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_full_q <= 1'b1;
                w_data_q <= S_AXI_WDATA[7:0];
                w_strb_q <= S_AXI_WSTRB[0];
            end
            if (wr_go) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (wr_sel == `PIC_SEL_NONE)
                    S_AXI_BRESP <= `PIC_RESP_SLVERR;
                else
                    S_AXI_BRESP <= `PIC_RESP_OKAY;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // read mux; pending reads show live state for polling
    reg  [7:0] rd_byte;
    always @* begin
        case (rd_sel)
            `PIC_SEL_CTRL:        rd_byte = {me_q, 7'h00};
            `PIC_SEL_PEND:        rd_byte = pend_q[7:0];
            `PIC_SEL_PEND + 4'h1: rd_byte = pend_q[15:8];
            `PIC_SEL_PEND + 4'h2: rd_byte = pend_q[23:16];
            `PIC_SEL_ENH:         rd_byte = enh_q[7:0];
            `PIC_SEL_ENH + 4'h1:  rd_byte = enh_q[15:8];
            `PIC_SEL_ENH + 4'h2:  rd_byte = enh_q[23:16];
            `PIC_SEL_ENL:         rd_byte = enl_q[7:0];
            `PIC_SEL_ENL + 4'h1:  rd_byte = enl_q[15:8];
            `PIC_SEL_ENL + 4'h2:  rd_byte = enl_q[23:16];
            default:              rd_byte = `PIC_RST_BYTE;
        endcase
    end

    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `PIC_RESP_OKAY;
        end else if (CLK_EN_I) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= {24'h000000, rd_byte};
                if (rd_sel == `PIC_SEL_NONE)
                    S_AXI_RRESP <= `PIC_RESP_SLVERR;
                else
                    S_AXI_RRESP <= `PIC_RESP_OKAY;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule // pic_top

// ===== test/pic_top_props.sv
// Purpose: port checker for the prioritising interrupt controller
// Assumes: bound into pic_top; answers are registered, one cycle late, write responses two
// Notes:   frozen clock enable and reset both suspend the checks
`timescale 1ns/100ps
module pic_chk (
    // clock, reset and cpu events
    input wire        SYS_CLK_I, RST_B_I, CLK_EN_I, INT_ACK_I, WDT_INT_I,
    input wire        GLOBAL_UNMASK_INSTR_I, GLOBAL_MASK_INSTR_I,
    input wire        RETURN_FROM_SERVICE_INSTR_I, TRAP_INSTR_I,
    input wire        ILLEGAL_TRAP_I, PRI_OSC_FAIL_I, WDT_OSC_FAIL_I,
    // cpu request side
    input wire        INT_REQ_O, INT_SYS_O, MASTER_INT_ENABLE_O,
    input wire [15:0] INT_VEC_MSB_ADDR_O, INT_VEC_LSB_ADDR_O,
    // bus handshakes
    input wire        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID,
    input wire        S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY,
    input wire        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I || !CLK_EN_I);
    wire trap = ILLEGAL_TRAP_I | PRI_OSC_FAIL_I | WDT_OSC_FAIL_I;
    // every clear source but a written 0; clears win over sets
    wire clr  = trap | GLOBAL_MASK_INSTR_I | TRAP_INSTR_I |
                (INT_ACK_I & INT_REQ_O);

    property p_gate;
        $rose(INT_REQ_O) && !INT_SYS_O |-> $past(MASTER_INT_ENABLE_O);
    endproperty
    a_gate: assert property (p_gate)
        else $error("request forwarded while disabled");
    property p_clr;
        clr |=> !MASTER_INT_ENABLE_O;
    endproperty
    a_clr: assert property (p_clr)
        else $error("master enable not cleared");
    property p_set;
        (GLOBAL_UNMASK_INSTR_I | RETURN_FROM_SERVICE_INSTR_I) && !clr
            |=> MASTER_INT_ENABLE_O;
    endproperty
    a_set: assert property (p_set)
        else $error("master enable not set");
    property p_stand;
        INT_REQ_O && !INT_ACK_I |=> INT_REQ_O;
    endproperty
    a_stand: assert property (p_stand)
        else $error("request dropped without acknowledge");
    property p_pair;
        INT_REQ_O |-> !INT_VEC_MSB_ADDR_O[0] &&
            INT_VEC_LSB_ADDR_O == (INT_VEC_MSB_ADDR_O | 16'h0001);
    endproperty
    a_pair: assert property (p_pair)
        else $error("vector byte addresses do not pair");
    property p_trap;
        trap && !INT_REQ_O |=> INT_REQ_O && INT_SYS_O &&
            INT_VEC_MSB_ADDR_O inside {16'h0004, 16'h003a, 16'h003c, 16'h0006};
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap not forwarded as system event");
    property p_wdt;
        WDT_INT_I && MASTER_INT_ENABLE_O && !clr && !INT_REQ_O
            |=> INT_REQ_O && INT_VEC_MSB_ADDR_O == 16'h0004;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog interrupt not on top");
    property p_bresp;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |-> ##2 S_AXI_BVALID;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
    property p_bwait;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    a_bwait: assert property (p_bwait)
        else $error("write response withdrawn");
    property p_rlat;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_rlat: assert property (p_rlat)
        else $error("read data late");
endmodule // pic_chk

bind pic_top pic_chk chk_i (
    .SYS_CLK_I, .RST_B_I, .CLK_EN_I, .INT_ACK_I, .WDT_INT_I,
    .GLOBAL_UNMASK_INSTR_I, .GLOBAL_MASK_INSTR_I,
    .RETURN_FROM_SERVICE_INSTR_I, .TRAP_INSTR_I, .ILLEGAL_TRAP_I,
    .PRI_OSC_FAIL_I, .WDT_OSC_FAIL_I, .INT_REQ_O, .INT_SYS_O,
    .MASTER_INT_ENABLE_O, .INT_VEC_MSB_ADDR_O, .INT_VEC_LSB_ADDR_O,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RVALID);

// ===== test/pic_cpu_model.sv
// Purpose: cpu core stand-in that acknowledges forwarded requests
// Assumes: one acknowledge pulse per request, after lat_i waiting cycles
// Notes:   never acknowledges an idle request line
`timescale 1ns/100ps
module pic_cpu_model (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_b_i,
    // request and acknowledge
    input  wire       req_i,
    input  wire [1:0] lat_i,
    output reg        ack_o
);
    reg [1:0] cnt_q;
    // only a standing request is acknowledged, and only once
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_o <= 1'h0;
            cnt_q <= 2'h0;
        end else begin
            ack_o <= 1'h0;
            if (req_i && !ack_o && cnt_q == lat_i) begin
                ack_o <= 1'h1;
                cnt_q <= 2'h0;
            end else if (req_i && !ack_o) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule // pic_cpu_model

// ===== test/tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: cpu stand-in acknowledges; bus master is one task
// Notes:   request pulses last one cycle, system levels drop on ack
`timescale 1ns/100ps
`include "pic_defs.vh"
module tb;
    integer     seed = 45483, n_fail = 0, samples_checked = 0, t;
    reg         clk = 0, rst_b = 0, awv = 0, wv = 0, arv = 0;
    reg         brdy = 0, rrdy = 0, ce = 1;
    reg  [3:0]  ev = 0, sysl = 0;
    reg  [1:0]  lat = 0, qr;
    reg  [23:0] src = 0, p, h, l, rp;
    reg  [13:0] ad = 0;
    reg  [31:0] wd = 0, q;
    reg  [11:0] k;
    reg  [4:0]  eidx;
    reg  [15:0] v;
    wire        awr, wrd, arr, bv, rv, irq, sys, me, ack;
    wire [1:0]  br, rs;
    wire [31:0] rd;
    wire [15:0] vm, vl;
    localparam [23:0] MSK = {`PIC_MASK_G0, `PIC_MASK_G1, `PIC_MASK_G2};
    always #20 clk = ~clk;
    pic_top dut (
        .SYS_CLK_I(clk), .RST_B_I(rst_b), .CLK_EN_I(ce),
        .TIMER1_REQ_I(src[22]), .TIMER0_REQ_I(src[21]),
        .CONVERTER_REQ_I(src[16]), .PORTA_REQ_I(src[15:8]),
        .PORTC_REQ_I(src[3:0]), .GLOBAL_UNMASK_INSTR_I(ev[0]),
        .GLOBAL_MASK_INSTR_I(ev[1]), .TRAP_INSTR_I(ev[2]),
        .RETURN_FROM_SERVICE_INSTR_I(ev[3]), .ILLEGAL_TRAP_I(sysl[0]),
        .PRI_OSC_FAIL_I(sysl[1]), .WDT_OSC_FAIL_I(sysl[2]),
        .WDT_INT_I(sysl[3]), .INT_ACK_I(ack), .INT_REQ_O(irq),
        .INT_SYS_O(sys), .INT_VEC_MSB_ADDR_O(vm), .INT_VEC_LSB_ADDR_O(vl),
        .MASTER_INT_ENABLE_O(me), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_AWADDR(ad), .S_AXI_AWPROT(3'h0),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
        .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ad), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rrdy), .S_AXI_RDATA(rd), .S_AXI_RRESP(rs));
    pic_cpu_model cpu (.clk_i(clk), .rst_b_i(rst_b), .req_i(irq),
                       .lat_i(lat), .ack_o(ack));

    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // one bus transfer; ready to accept the answer after a random wait
    task axi(input wr, input [11:0] i, input [7:0] d);
        reg a, w;
        begin
            a = 0;
            w = !wr;
            ad <= {i, 2'h0};
            wd <= {24'h0, d};
            if (wr) begin
                awv <= 1;
                wv <= 1;
            end else arv <= 1;
            while (!(a && w)) begin
                @(posedge clk);
                if (wr && awv && awr) begin a = 1; awv <= 0; end
                if (wr && wv && wrd) begin w = 1; wv <= 0; end
                if (!wr && arr) begin a = 1; arv <= 0; end
            end
            repeat ($random(seed) & 1) @(posedge clk);
            brdy <= wr;
            rrdy <= !wr;
            @(posedge clk);
            while (!(wr ? bv : rv)) @(posedge clk);
            q = rd;
            qr = wr ? br : rs;
            brdy <= 0;
            rrdy <= 0;
        end
    endtask
    task rdp;
        reg [1:0] g;
        begin
            for (g = 0; g < 3; g = g + 1) begin
                axi(0, `PIC_IDX_PEND0 + 3 * g, 8'h00);
                rp[23 - 8 * g -: 8] = q[7:0];
            end
            chk(qr, `PIC_RESP_OKAY);
        end
    endtask
    task pulse(input [3:0] e);
        begin
            ev <= e;
            @(posedge clk);
            ev <= 0;
        end
    endtask
    task irq_wait(input [15:0] ve, input s);
        integer n;
        begin
            n = 0;
            while (!irq && n < 20) begin @(posedge clk); n = n + 1; end
            chk(vm, ve);
            chk(sys, s);
            chk(vl, ve | 16'h1);
            while (!(irq && ack) && n < 40) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(n < 40, 1);
            sysl <= 0;
            @(posedge clk);
            chk(me, 0);
        end
    endtask
    // highest level first, then lowest vector address
    function [15:0] exp_vec(input [23:0] pp, input [23:0] hh, ll);
        integer lv, x;
        reg [4:0] i;
        begin
            exp_vec = 0;
            for (lv = 3; lv > 0; lv = lv - 1)
                for (x = 10; x <= 54; x = x + 2) begin
                    i = x <= 22 ? 16 + (22 - x) / 2 :
                        x <= 38 ? 8 + (38 - x) / 2 : (54 - x) / 2;
                    if (exp_vec == 0 && pp[i] && {hh[i], ll[i]} == lv) begin
                        exp_vec = x;
                        eidx = i;
                    end
                end
        end
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        n_fail = n_fail + 1;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        rdp;
        chk(rp, 24'h0);
        axi(1, 12'hfc9, 8'hff);
        chk(qr, `PIC_RESP_SLVERR);
        axi(0, 12'hfc9, 8'h00);
        chk(qr, `PIC_RESP_SLVERR);
        for (k = 0; k < 6; k = k + 1) begin
            case (k)
                0: pulse(4'h1);
                1: pulse(4'h2);
                2: axi(1, `PIC_IDX_CTRL, 8'h80);
                3: pulse(4'h4);
                4: pulse(4'h8);
                default: axi(1, `PIC_IDX_CTRL, 8'h00);
            endcase
            axi(0, `PIC_IDX_CTRL, 8'h00);
            chk(q, k[0] ? 32'h0 : 32'h80);
        end
        p = 0;
        repeat (2) begin
            h = 24'($random(seed)) & MSK;
            src <= h;
            @(posedge clk);
            src <= 0;
            p = p | h;
            rdp;
            chk(rp, p);
        end
        // frozen clock enable: a pulse must not land
        ce <= 0;
        src <= MSK;
        @(posedge clk);
        src <= 0;
        ce <= 1;
        rdp;
        chk(rp, p);
        for (t = 0; t < 40; t = t + 1) begin
            p = 24'($random(seed));
            h = 24'($random(seed));
            l = 24'($random(seed));
            lat <= 2'($random(seed));
            if (t == 0) begin p = 24'h000101; h = 24'hffffff; l = h; end
            if (t == 1) begin p = 24'h400001; h = 24'h1; l = 24'h400001; end
            if (t % 4 == 3) begin h = 0; l = 0; end
            axi(1, `PIC_IDX_CTRL, 8'h00);
            for (k = 0; k < 3; k = k + 1) begin
                axi(1, `PIC_IDX_ENH0 + 3 * k, h[23 - 8 * k -: 8]);
                axi(1, `PIC_IDX_ENL0 + 3 * k, l[23 - 8 * k -: 8]);
                // whole register in one bus write
                axi(1, `PIC_IDX_PEND0 + 3 * k, p[23 - 8 * k -: 8]);
            end
            p = p & MSK;
            rdp;
            chk(rp, p);
            pulse(4'h1);
            v = exp_vec(p, h, l);
            if (v != 0) begin
                irq_wait(v, 0);
                p[eidx] = 0;
                rdp;
                chk(rp, p);
            end else begin
                repeat (4) @(posedge clk);
                chk(irq, 0);
            end
        end
        axi(1, `PIC_IDX_CTRL, 8'h00);
        for (k = 0; k < 3; k = k + 1) axi(1, `PIC_IDX_PEND0 + 3 * k, 8'h00);
        axi(1, `PIC_IDX_ENH1, 8'h80);
        axi(1, `PIC_IDX_ENL1, 8'h80);
        axi(1, `PIC_IDX_PEND1, 8'h80);
        repeat (4) @(posedge clk);
        chk(irq, 0);
        for (k = 0; k < 3; k = k + 1) begin
            sysl <= 4'h1 << k;
            irq_wait(k == 0 ? `PIC_VEC_ILL : k == 1 ? `PIC_VEC_POSC :
                     `PIC_VEC_WOSC, 1);
        end
        sysl <= 4'h8;
        repeat (4) @(posedge clk);
        chk(irq, 0);
        pulse(4'h1);
        irq_wait(`PIC_VEC_WDT, 1);
        pulse(4'h8);
        irq_wait(16'h0018, 0);
        rdp;
        chk(rp, 24'h0);
        give_verdict;
    end
endmodule // tb
